// File: src/lq_access_pkg.sv
package lq_access_pkg;

  // ==========================================================
  // Register map
  localparam logic [4:0] THRESHOLD_ACCESS_ADDR = 5'h1e;
  localparam int REG_WIDTH = 16;

  // ==========================================================
  // Field layout of the threshold access register
  localparam int RESERVED_MSB = 15;
  localparam int RESERVED_LSB = 14;
  localparam int SAMPLE_BIT = 13;
  localparam int TRIGGER_BIT = 12;
  localparam int PSEL_MSB = 11;
  localparam int PSEL_LSB = 9;
  localparam int LH_BIT = 8;
  localparam int DATA_MSB = 7;
  localparam int DATA_LSB = 0;

  // ==========================================================
  // Reset values and sizes
  localparam logic [7:0] DATA_RESET = 8'h80;
  localparam logic [7:0] THRESHOLD_RESET = 8'h80;
  localparam logic [2:0] PSEL_RESET = 3'h0;
  localparam int DATA_WIDTH = 8;
  localparam int NUM_PARAMS = 6;
  localparam int NUM_THRESHOLDS = 2 * NUM_PARAMS;
  localparam int INDEX_WIDTH = 4;

  // ==========================================================
  // Monitored parameter encodings
  typedef enum logic [2:0] {
    PARAM_EQUALISER = 3'h0,
    PARAM_GAIN = 3'h1,
    PARAM_BASELINE = 3'h2,
    PARAM_FREQ_OFFSET = 3'h3,
    PARAM_FREQ_CONTROL = 3'h4,
    PARAM_VARIANCE = 3'h5
  } param_sel_t;

endpackage

// File: src/threshold_store.sv
`timescale 1ns/1ns
module threshold_store
  import lq_access_pkg::*;
#(
  parameter int ENTRIES = lq_access_pkg::NUM_THRESHOLDS,
  parameter int WIDTH = lq_access_pkg::DATA_WIDTH
)
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic wr_en_in,
  input wire logic [lq_access_pkg::INDEX_WIDTH-1:0] wr_index_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic [lq_access_pkg::INDEX_WIDTH-1:0] rd_index_in,
  output logic [WIDTH-1:0] rd_data_out,
  output logic [ENTRIES*WIDTH-1:0] thresholds_out
);

  logic [WIDTH-1:0] entry [ENTRIES];

  // ==========================================================
  // One flip-flop byte per threshold
  genvar g;
  generate
    for (g = 0; g < ENTRIES; g++)
    begin : g_entry
      logic [WIDTH-1:0] next_entry;
      always_comb
      begin
        next_entry = entry[g];
        if (wr_en_in && (int'(wr_index_in) == g))
        begin
          next_entry = wr_data_in;
        end
      end
      always_ff @(posedge clk_in)
      begin
        if (reset_in)
        begin
          entry[g] <= WIDTH'(THRESHOLD_RESET);
        end
        else
        begin
          entry[g] <= next_entry;
        end
      end
      assign thresholds_out[g*WIDTH +: WIDTH] = entry[g];
    end
  endgenerate

  // Unused encodings read as zero
  always_comb
  begin
    rd_data_out = '0;
    if (int'(rd_index_in) < ENTRIES)
    begin
      rd_data_out = entry[rd_index_in];
    end
  end

endmodule // threshold_store

// File: src/link_quality_threshold_access.sv
// Operation
// - Bits 15:14 ignore writes and always read as zero.
// - Setting sample control starts sampling and data field returns parameter values.
// - Writing trigger one stores data into the selected threshold.
// - Trigger bit is a strobe and always reads zero.
// - Parameter select codes 000 to 101 name the six monitored parameters.
// - One parameter select serves both sampling and threshold access.
// - Low/high select zero picks low threshold, one picks high.
// - For variance, low/high picks byte of bits 23:16 or 31:24.
// - Data field resets to 0x80 and carries the value written.
// - With sampling off, reads return the selected threshold.
// - With sampling on, reads return the captured value, held until resampled.
// - Threshold writes are ignored while the device is powered down.
// - Monitor runs only while enabled and a 100 Mb link is valid.
`timescale 1ns/1ns
module link_quality_threshold_access
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [4:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [lq_access_pkg::REG_WIDTH-1:0] reg_wdata_in,
  output logic [lq_access_pkg::REG_WIDTH-1:0] reg_rdata_out,
  input wire logic power_down_in,
  input wire logic monitor_enable_in,
  input wire logic link_100_valid_in,
  input wire logic [7:0] equaliser_coefficient_in,
  input wire logic [7:0] gain_control_parameter_in,
  input wire logic [7:0] baseline_wander_parameter_in,
  input wire logic [7:0] frequency_offset_in,
  input wire logic [7:0] frequency_control_in,
  input wire logic [31:0] variance_in,
  output logic monitor_active_out,
  output logic [lq_access_pkg::NUM_THRESHOLDS*lq_access_pkg::DATA_WIDTH-1:0] thresholds_out
);
  import lq_access_pkg::*;

  logic sample_control;
  logic [2:0] parameter_select;
  logic low_high_select;
  logic [7:0] threshold_data_field;
  logic [7:0] sample_value;
  logic next_sample_control;
  logic [2:0] next_parameter_select;
  logic next_low_high_select;
  logic [7:0] next_threshold_data_field;
  logic [7:0] next_sample_value;
  logic [15:0] next_rdata;
  logic next_monitor_active;
  logic reg_hit;
  logic wr_hit;
  logic threshold_write;
  logic [7:0] thr_sel_value;
  logic [7:0] live_value;
  logic [2:0] wr_psel;
  logic wr_lh;

  // ==========================================================
  // Register decode
  assign reg_hit = (reg_addr_in == THRESHOLD_ACCESS_ADDR);
  assign wr_hit = reg_wr_in && reg_hit;
  assign wr_psel = reg_wdata_in[PSEL_MSB:PSEL_LSB];
  assign wr_lh = reg_wdata_in[LH_BIT];
  // Power-down blocks the store; the trigger itself is never held
  assign threshold_write = wr_hit && reg_wdata_in[TRIGGER_BIT] && !power_down_in;

  // ==========================================================
  // Threshold storage, indexed by {parameter, low/high}
  threshold_store #(
    .ENTRIES(NUM_THRESHOLDS),
    .WIDTH(DATA_WIDTH)
  ) u_store (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .wr_en_in(threshold_write),
    .wr_index_in({wr_psel, wr_lh}),
    .wr_data_in(reg_wdata_in[DATA_MSB:DATA_LSB]),
    .rd_index_in({parameter_select, low_high_select}),
    .rd_data_out(thr_sel_value),
    .thresholds_out(thresholds_out)
  );

  // ==========================================================
  // Live parameter selection, driven by the fields of the current write
  always_comb
  begin
    case (param_sel_t'(wr_psel))
      PARAM_EQUALISER: live_value = equaliser_coefficient_in;
      PARAM_GAIN: live_value = gain_control_parameter_in;
      PARAM_BASELINE: live_value = baseline_wander_parameter_in;
      PARAM_FREQ_OFFSET: live_value = frequency_offset_in;
      PARAM_FREQ_CONTROL: live_value = frequency_control_in;
      PARAM_VARIANCE: live_value = wr_lh ? variance_in[31:24] : variance_in[23:16];
      default: live_value = 8'h00;
    endcase
  end

  // ==========================================================
  // Control fields and sample capture
  always_comb
  begin
    next_sample_control = sample_control;
    next_parameter_select = parameter_select;
    next_low_high_select = low_high_select;
    next_threshold_data_field = threshold_data_field;
    next_sample_value = sample_value;
    next_monitor_active = monitor_enable_in && link_100_valid_in;
    if (wr_hit)
    begin
      // Bits 15:14 and the trigger are not stored
      next_sample_control = reg_wdata_in[SAMPLE_BIT];
      next_parameter_select = wr_psel;
      next_low_high_select = wr_lh;
      next_threshold_data_field = reg_wdata_in[DATA_MSB:DATA_LSB];
      // A frozen monitor has no fresh value, so the old capture is kept
      if (reg_wdata_in[SAMPLE_BIT] && monitor_active_out)
      begin
        next_sample_value = live_value;
      end
    end
  end

  always_comb
  begin
    next_rdata = 16'h0000;
    if (reg_rd_in && reg_hit)
    begin
      next_rdata[SAMPLE_BIT] = sample_control;
      next_rdata[PSEL_MSB:PSEL_LSB] = parameter_select;
      next_rdata[LH_BIT] = low_high_select;
      next_rdata[DATA_MSB:DATA_LSB] = sample_control ? sample_value : thr_sel_value;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      sample_control <= 1'b0;
      parameter_select <= PSEL_RESET;
      low_high_select <= 1'b0;
      threshold_data_field <= DATA_RESET;
      sample_value <= 8'h00;
      reg_rdata_out <= 16'h0000;
      monitor_active_out <= 1'b0;
    end
    else
    begin
      sample_control <= next_sample_control;
      parameter_select <= next_parameter_select;
      low_high_select <= next_low_high_select;
      threshold_data_field <= next_threshold_data_field;
      sample_value <= next_sample_value;
      reg_rdata_out <= next_rdata;
      monitor_active_out <= next_monitor_active;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  AST_RESERVED_ZERO: assert property (
    reg_rd_in && reg_hit |=> reg_rdata_out[RESERVED_MSB:RESERVED_LSB] == 2'b00)
    else $error("Reserved bits read nonzero");

  // A host needs a spare cycle between strobes, so the read follows a few cycles later
  AST_TRIGGER_READS_ZERO: assert property (
    wr_hit && reg_wdata_in[TRIGGER_BIT] ##[1:4] reg_rd_in && reg_hit
    |=> !reg_rdata_out[TRIGGER_BIT])
    else $error("Trigger bit read back as one");

  AST_SAMPLE_FLAG: assert property (
    wr_hit ##1 !wr_hit ##1 reg_rd_in && reg_hit
    |=> reg_rdata_out[SAMPLE_BIT] == $past(reg_wdata_in[SAMPLE_BIT], 3))
    else $error("Sample control did not follow the write");

  AST_WRITE_STORES: assert property (
    threshold_write && wr_psel <= 3'h5 && !reg_wdata_in[SAMPLE_BIT]
    |=> thr_sel_value == $past(reg_wdata_in[DATA_MSB:DATA_LSB]))
    else $error("Triggered write not stored in selected threshold");

  AST_POWER_DOWN_BLOCKS: assert property (
    power_down_in |=> $stable(thresholds_out))
    else $error("Threshold changed while powered down");

  AST_READ_THRESHOLD: assert property (
    reg_rd_in && reg_hit && !sample_control
    |=> reg_rdata_out[DATA_MSB:DATA_LSB] == $past(thr_sel_value))
    else $error("Threshold read returned wrong value");

  AST_READ_SAMPLE: assert property (
    reg_rd_in && reg_hit && sample_control
    |=> reg_rdata_out[DATA_MSB:DATA_LSB] == $past(sample_value))
    else $error("Sample read returned wrong value");

  AST_SAMPLE_HELD: assert property (
    !wr_hit |=> $stable(sample_value))
    else $error("Captured sample changed without a new sequence");

  AST_VARIANCE_BYTE: assert property (
    wr_hit && reg_wdata_in[SAMPLE_BIT] && monitor_active_out && wr_psel == 3'h5
    |=> sample_value == ($past(wr_lh) ? $past(variance_in[31:24]) : $past(variance_in[23:16])))
    else $error("Variance byte capture wrong");

  AST_MONITOR_GATE: assert property (
    !(monitor_enable_in && link_100_valid_in) |=> !monitor_active_out)
    else $error("Monitor active without enable and link");

  AST_DATA_RESET: assert property (
    $past(reset_in) |-> threshold_data_field == DATA_RESET)
    else $error("Data field not at reset value");

endmodule // link_quality_threshold_access

// File: test/mgmt_host.sv
`timescale 1ns/1ns
// ==========================================
// Management host: one strobe per access, fields held until the taking edge
module mgmt_host
(
  input wire logic clk_in,
  input wire logic [15:0] rdata_in,
  output logic [4:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [15:0] wdata_out
);
  initial
  begin
    addr_out = 5'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 16'h0000;
  end

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    // Released data must not look valid
    wdata_out <= ~d;
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    #1;
    d = rdata_in;
  endtask
endmodule // mgmt_host

// File: test/link_quality_threshold_access_test.sv
`timescale 1ns/1ns
module link_quality_threshold_access_test;
  import lq_access_pkg::*;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic power_down_in = 1'b0;
  logic enable = 1'b0;
  logic link = 1'b0;
  logic [7:0] lv [0:4];
  logic [31:0] variance;
  logic [4:0] addr;
  logic wr;
  logic rd;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic active;
  logic [95:0] thr_bus;
  logic [7:0] thr [0:11];
  logic [7:0] cap;
  logic [15:0] got;
  int num_errors = 0;
  int num_checks = 0;
  int seed = 32'h26e2;

  always #50 clk_in = ~clk_in;

  link_quality_threshold_access link_quality_threshold_access_inst (.clk_in(clk_in),
    .reset_in(reset_in), .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .power_down_in(power_down_in),
    .monitor_enable_in(enable), .link_100_valid_in(link),
    .equaliser_coefficient_in(lv[0]), .gain_control_parameter_in(lv[1]),
    .baseline_wander_parameter_in(lv[2]), .frequency_offset_in(lv[3]),
    .frequency_control_in(lv[4]), .variance_in(variance),
    .monitor_active_out(active), .thresholds_out(thr_bus));

  mgmt_host mgmt_host_inst (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr),
    .wr_out(wr), .rd_out(rd), .wdata_out(wdata));

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  function automatic logic [7:0] live(input logic [2:0] p, input logic lh,
    input logic [39:0] l, input logic [31:0] v);
    if (p == 3'h5)
      return lh ? v[31:24] : v[23:16];
    return l[8*p +: 8];
  endfunction

  // Reserved bits are written as ones to show they are dropped
  task automatic put(input logic [2:0] p, input logic lh, input logic [7:0] d8, input logic t);
    int k;
    k = 2 * p + lh;
    mgmt_host_inst.wr(THRESHOLD_ACCESS_ADDR, {2'b11, 1'b0, t, p, lh, d8});
    if (t && !power_down_in)
      thr[k] = d8;
    mgmt_host_inst.rd(THRESHOLD_ACCESS_ADDR, got);
    chk(got, {4'h0, p, lh, thr[k]});
    for (int i = 0; i < 12; i++)
      chk({8'h00, thr_bus[8*i +: 8]}, {8'h00, thr[i]});
  endtask

  task automatic samp(input logic [2:0] p, input logic lh, input logic act);
    logic [39:0] nlv;
    logic [31:0] nvar;
    for (int i = 0; i < 5; i++)
      nlv[8*i +: 8] = 8'($random(seed));
    nvar = $random(seed);
    @(posedge clk_in);
    for (int i = 0; i < 5; i++)
      lv[i] <= nlv[8*i +: 8];
    variance <= nvar;
    if (act)
      cap = live(p, lh, nlv, nvar);
    mgmt_host_inst.wr(THRESHOLD_ACCESS_ADDR, {2'b00, 1'b1, 1'b0, p, lh, 8'h00});
    // Live values move on at once; the capture must not follow them
    variance <= ~variance;
    for (int i = 0; i < 5; i++)
      lv[i] <= ~lv[i];
    repeat (2)
    begin
      mgmt_host_inst.rd(THRESHOLD_ACCESS_ADDR, got);
      chk(got, {2'b00, 1'b1, 1'b0, p, lh, cap});
    end
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_in);
    num_errors++;
    end_of_test();
  end

  initial
  begin
    for (int i = 0; i < 5; i++)
      lv[i] = 8'h00;
    variance = 32'h0000_0000;
    cap = 8'h00;
    for (int i = 0; i < 12; i++)
      thr[i] = THRESHOLD_RESET;
    repeat (12) @(posedge clk_in);
    reset_in <= 1'b0;
    for (int k = 0; k < 12; k++)
      put(3'(k / 2), k[0], 8'h00, 1'b0);
    repeat (3)
      for (int k = 0; k < 12; k++)
        put(3'(k / 2), k[0], 8'($random(seed)), 1'b1);
    @(posedge clk_in);
    power_down_in <= 1'b1;
    put(3'h3, 1'b1, 8'h5a, 1'b1);
    @(posedge clk_in);
    power_down_in <= 1'b0;
    put(3'h3, 1'b1, 8'h5a, 1'b1);
    mgmt_host_inst.wr(5'h1d, 16'h1aff);
    mgmt_host_inst.rd(5'h1d, got);
    chk(got, 16'h0000);
    // Unused parameter code: the trigger stores nothing and the threshold reads zero
    mgmt_host_inst.wr(THRESHOLD_ACCESS_ADDR, {4'h1, 3'h6, 1'b1, 8'h3c});
    mgmt_host_inst.rd(THRESHOLD_ACCESS_ADDR, got);
    chk(got, {4'h0, 3'h6, 1'b1, 8'h00});
    put(3'h5, 1'b0, 8'h00, 1'b0);
    @(posedge clk_in);
    enable <= 1'b1;
    link <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    chk({15'h0000, active}, 16'h0001);
    for (int k = 0; k < 12; k++)
      samp(3'(k / 2), k[0], 1'b1);
    @(posedge clk_in);
    link <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    chk({15'h0000, active}, 16'h0000);
    samp(3'h1, 1'b0, 1'b0);
    put(3'h0, 1'b0, 8'h00, 1'b0);
    end_of_test();
  end
endmodule // link_quality_threshold_access_test
